// >>> src/msc_regs.svh
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH

// bus register byte offsets
`define MSC_IAC_OFS 8'h00
`define MSC_DLO_OFS 8'h04
`define MSC_DHI_OFS 8'h08
`define MSC_CFG_OFS 8'h0C

// indirect access control word fields
`define MSC_IAC_W 13
`define MSC_IAC_RD_BIT 12
`define MSC_IAC_SEL_HI 11
`define MSC_IAC_SEL_LO 10
`define MSC_IAC_SEL_MIB 2'h3
`define MSC_IAC_ADDR_HI 9
`define MSC_IAC_RST 13'h0000

// indirect counter offsets
`define MSC_OFS_RX65 10'h00F
`define MSC_OFS_RX128 10'h010
`define MSC_OFS_RX256 10'h011
`define MSC_OFS_RX512 10'h012
`define MSC_OFS_RX1024 10'h013
`define MSC_OFS_TXLO 10'h014
`define MSC_OFS_TXHI 10'h015
`define MSC_OFS_LATE 10'h016
`define MSC_OFS_PAUSE 10'h017
`define MSC_OFS_BC 10'h018
`define MSC_OFS_MC 10'h019
`define MSC_OFS_UC 10'h01A
`define MSC_OFS_DEF 10'h01B
`define MSC_OFS_TOT 10'h01C
`define MSC_OFS_ABN 10'h01D
`define MSC_OFS_ONE 10'h01E
`define MSC_OFS_MUL 10'h01F
`define MSC_OFS_TXDROP 10'h100
`define MSC_OFS_RXDROP 10'h103
`define MSC_NCNT 17

// counter word layout
`define MSC_OVF_BIT 31
`define MSC_VLD_BIT 30
`define MSC_HALF_LO 15
`define MSC_HALF_HI 16

// length bin edges and limits
`define MSC_LEN_65 11'h041
`define MSC_LEN_127 11'h07F
`define MSC_LEN_128 11'h080
`define MSC_LEN_255 11'h0FF
`define MSC_LEN_256 11'h100
`define MSC_LEN_511 11'h1FF
`define MSC_LEN_512 11'h200
`define MSC_LEN_1023 11'h3FF
`define MSC_LEN_1024 11'h400
`define MSC_MAXLEN_RST 11'h7D0
`define MSC_LATE_BT 16'h0200

// configuration register fields
`define MSC_CFG_HD_BIT 16
`define MSC_CFG_HD_RST 1'b0

`endif

// >>> src/msc_pkg.sv
package msc_pkg;

    // one received frame, pulsed for one cycle at frame end
    typedef struct packed {
        logic done;
        logic [10:0] len;
    } msc_rx_evt_s;

    // one transmitted frame, pulsed for one cycle at frame end
    typedef struct packed {
        logic done;
        logic good;
        logic high_prio;
        logic pause;
        logic bcast;
        logic mcast;
        logic deferred;
        logic abandoned;
        logic [4:0] coll_num;
        logic [10:0] octets;
    } msc_tx_evt_s;

    // one collision, with its position in bit-times from frame start
    typedef struct packed {
        logic hit;
        logic [15:0] bit_pos;
    } msc_coll_evt_s;

    typedef logic [29:0] msc_cnt_t;
    typedef logic [15:0] msc_drop_t;

endpackage : msc_pkg

// >>> src/msc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "msc_regs.svh"

// What this block does
// - count received frames in 65-127, 128-255, 256-511, 512-1023 octet bins
// - count received frames from 1024 octets up to configured maximum size
// - add good transmitted octets to low or high priority totals
// - count collisions seen later than 512 bit-times into a frame
// - count transmitted flow control frames
// - count good broadcast, multicast, unicast transmits, mutually exclusive
// - count frames whose first attempt was postponed by busy medium
// - total collisions, counted only in half duplex
// - count frames abandoned after excessive collisions
// - count good frames after exactly one, and after several, collisions
// - drop counters give 16 read-only bits, zero at reset, no flags
// - offset 0x100 transmit drops, 0x103 receive drops, others empty
// - reading a statistics counter clears it
// - reading a drop counter leaves it unchanged
// - counter word holds overflow, valid and 30-bit count, zero at reset
// - lower data register gives bits 15-0, upper gives bits 31-16
module msc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire msc_pkg::msc_rx_evt_s rx_evt,
    input wire msc_pkg::msc_tx_evt_s tx_evt,
    input wire msc_pkg::msc_coll_evt_s coll_evt,
    input wire logic tx_drop,
    input wire logic rx_drop
);

    localparam int I_B65 = 0;
    localparam int I_B1024 = `MSC_OFS_RX1024 - `MSC_OFS_RX65;
    localparam int I_TXHI = `MSC_OFS_TXHI - `MSC_OFS_RX65;
    localparam int I_LATE = `MSC_OFS_LATE - `MSC_OFS_RX65;
    localparam int I_MC = `MSC_OFS_MC - `MSC_OFS_RX65;
    localparam int I_TOT = `MSC_OFS_TOT - `MSC_OFS_RX65;

    // inclusive length window test, shared by all length bins
    function automatic logic msc_in_rng(
        input logic [10:0] len,
        input logic [10:0] lo,
        input logic [10:0] hi
    );
        msc_in_rng = (len >= lo) && (len <= hi);
    endfunction : msc_in_rng

    // amount each counter grows by this cycle
    function automatic msc_pkg::msc_cnt_t msc_amt(
        input logic [9:0] ofs,
        input msc_pkg::msc_rx_evt_s rx,
        input msc_pkg::msc_tx_evt_s tx,
        input msc_pkg::msc_coll_evt_s co,
        input logic hd,
        input logic [10:0] maxlen
    );
        logic good;
        msc_pkg::msc_cnt_t octs;
        good = tx.done & tx.good;
        octs = {19'h00000, tx.octets};
        case (ofs)
            `MSC_OFS_RX65: msc_amt = 30'(rx.done && msc_in_rng(rx.len,
                `MSC_LEN_65, `MSC_LEN_127));
            `MSC_OFS_RX128: msc_amt = 30'(rx.done && msc_in_rng(rx.len,
                `MSC_LEN_128, `MSC_LEN_255));
            `MSC_OFS_RX256: msc_amt = 30'(rx.done && msc_in_rng(rx.len,
                `MSC_LEN_256, `MSC_LEN_511));
            `MSC_OFS_RX512: msc_amt = 30'(rx.done && msc_in_rng(rx.len,
                `MSC_LEN_512, `MSC_LEN_1023));
            `MSC_OFS_RX1024: msc_amt = 30'(rx.done && msc_in_rng(rx.len,
                `MSC_LEN_1024, maxlen));
            `MSC_OFS_TXLO: msc_amt = (good && !tx.high_prio) ? octs : '0;
            `MSC_OFS_TXHI: msc_amt = (good && tx.high_prio) ? octs : '0;
            `MSC_OFS_LATE: msc_amt = 30'(co.hit && (co.bit_pos >
                `MSC_LATE_BT));
            `MSC_OFS_PAUSE: msc_amt = 30'(tx.done && tx.pause);
            `MSC_OFS_BC: msc_amt = 30'(good && tx.bcast);
            `MSC_OFS_MC: msc_amt = 30'(good && tx.mcast && !tx.bcast);
            `MSC_OFS_UC: msc_amt = 30'(good && !tx.bcast && !tx.mcast);
            `MSC_OFS_DEF: msc_amt = 30'(tx.done && tx.deferred);
            `MSC_OFS_TOT: msc_amt = 30'(co.hit && hd);
            `MSC_OFS_ABN: msc_amt = 30'(tx.done && tx.abandoned);
            `MSC_OFS_ONE: msc_amt = 30'(good && (tx.coll_num == 5'h01));
            `MSC_OFS_MUL: msc_amt = 30'(good && (tx.coll_num > 5'h01));
            default: msc_amt = '0;
        endcase
    endfunction : msc_amt

    // bus state
    logic wr_dp_r;
    logic rd_dp_r;
    logic rd_done_r;
    logic [7:0] ap_addr_r;
    logic [31:0] hrdata_r;

    // register state
    logic [`MSC_IAC_W-1:0] iac_r;
    logic [10:0] maxlen_r;
    logic hd_r;
    logic pend_r;
    logic [31:0] data_r;

    // counter storage
    msc_pkg::msc_cnt_t cnt_r [`MSC_NCNT];
    msc_pkg::msc_cnt_t cnt_nxt [`MSC_NCNT];
    msc_pkg::msc_cnt_t amt [`MSC_NCNT];
    logic ovf_r [`MSC_NCNT];
    logic ovf_nxt [`MSC_NCNT];
    msc_pkg::msc_drop_t txd_r;
    msc_pkg::msc_drop_t rxd_r;

    // address phase decode
    wire acc = hsel & htrans[1] & hready;
    wire acc_wr = acc & hwrite;
    wire acc_rd = acc & ~hwrite;
    wire wr_commit = wr_dp_r & hready;
    wire wr_iac = wr_commit & (ap_addr_r == `MSC_IAC_OFS);
    wire wr_cfg = wr_commit & (ap_addr_r == `MSC_CFG_OFS);

    // indirect control decode
    wire [1:0] w_sel = hwdata[`MSC_IAC_SEL_HI:`MSC_IAC_SEL_LO];
    wire trig = wr_iac & hwdata[`MSC_IAC_RD_BIT] & (w_sel == `MSC_IAC_SEL_MIB);
    wire [9:0] lat_ofs = iac_r[`MSC_IAC_ADDR_HI:0];
    wire lat_cnt = (lat_ofs >= `MSC_OFS_RX65) && (lat_ofs <= `MSC_OFS_MUL);
    wire [9:0] lat_rel = lat_ofs - `MSC_OFS_RX65;
    wire [4:0] lat_idx = lat_rel[4:0];

    // a read waits one cycle, and longer while a latch is pending, so a fresh latch is always seen
    wire rd_cap = rd_dp_r & ~rd_done_r & ~pend_r;

    assign hreadyout = ~rd_dp_r | rd_done_r;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // read data selection from the registered address
    logic [31:0] rd_mux;
    always_comb begin
        case (ap_addr_r)
            `MSC_IAC_OFS: rd_mux = {19'h00000, iac_r};
            `MSC_DLO_OFS: rd_mux = {16'h0000,
                data_r[`MSC_HALF_LO:0]};
            `MSC_DHI_OFS: rd_mux = {16'h0000,
                data_r[31:`MSC_HALF_HI]};
            `MSC_CFG_OFS: rd_mux = {15'h0000, hd_r, 5'h00, maxlen_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // latched word for the addressed counter
    logic [31:0] lat_word;
    always_comb begin
        if (lat_cnt) begin
            lat_word = {ovf_r[lat_idx], 1'b1, cnt_r[lat_idx]};
        end else if (lat_ofs == `MSC_OFS_TXDROP) begin
            lat_word = {16'h0000, txd_r};
        end else if (lat_ofs == `MSC_OFS_RXDROP) begin
            lat_word = {16'h0000, rxd_r};
        end else begin
            lat_word = 32'h40000000;
        end
    end

    // counter update; a read-clear in the same cycle as an event keeps it
    always_comb begin
        logic [30:0] sum;
        logic clr;
        sum = '0;
        clr = 1'b0;
        for (int i = 0; i < `MSC_NCNT; i++) begin
            amt[i] = msc_amt(10'(i) + `MSC_OFS_RX65, rx_evt, tx_evt,
                coll_evt, hd_r, maxlen_r);
            sum = {1'b0, cnt_r[i]} + {1'b0, amt[i]};
            clr = pend_r & lat_cnt & (lat_idx == 5'(i));
            cnt_nxt[i] = clr ? amt[i] : sum[29:0];
            ovf_nxt[i] = clr ? 1'b0 : (ovf_r[i] | sum[30]);
        end
    end

    // bus phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dp_r <= 1'b0;
            rd_dp_r <= 1'b0;
            rd_done_r <= 1'b0;
            ap_addr_r <= 8'h00;
        end else if (hready) begin
            wr_dp_r <= acc_wr;
            rd_dp_r <= acc_rd;
            rd_done_r <= 1'b0;
            if (acc) begin
                ap_addr_r <= haddr[7:0];
            end
        end else if (rd_cap) begin
            rd_done_r <= 1'b1;
        end
    end

    // read data flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (rd_cap) begin
            hrdata_r <= rd_mux;
        end
    end

    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iac_r <= `MSC_IAC_RST;
            maxlen_r <= `MSC_MAXLEN_RST;
            hd_r <= `MSC_CFG_HD_RST;
        end else begin
            if (wr_iac) begin
                iac_r <= hwdata[`MSC_IAC_W-1:0];
            end
            if (wr_cfg) begin
                maxlen_r <= hwdata[10:0];
                hd_r <= hwdata[`MSC_CFG_HD_BIT];
            end
        end
    end

    // indirect latch: valid drops on trigger, rises when the word is taken, except for the two drop counters
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r <= 1'b0;
            data_r <= 32'h00000000;
        end else if (trig) begin
            pend_r <= 1'b1;
            data_r <= 32'h00000000;
        end else if (pend_r) begin
            pend_r <= 1'b0;
            data_r <= lat_word;
        end
    end

    // statistics counters
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `MSC_NCNT; i++) begin
                cnt_r[i] <= '0;
                ovf_r[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < `MSC_NCNT; i++) begin
                cnt_r[i] <= cnt_nxt[i];
                ovf_r[i] <= ovf_nxt[i];
            end
        end
    end

    // drop counters wrap silently and survive reads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txd_r <= 16'h0000;
            rxd_r <= 16'h0000;
        end else begin
            txd_r <= txd_r + 16'(tx_drop);
            rxd_r <= rxd_r + 16'(rx_drop);
        end
    end

    // checks on the counting and read paths
    wire clr_b65 = pend_r & lat_cnt & (lat_idx == 5'(I_B65));
    wire clr_b1024 = pend_r & lat_cnt & (lat_idx == 5'(I_B1024));
    wire clr_txhi = pend_r & lat_cnt & (lat_idx == 5'(I_TXHI));
    wire clr_late = pend_r & lat_cnt & (lat_idx == 5'(I_LATE));
    wire clr_mc = pend_r & lat_cnt & (lat_idx == 5'(I_MC));
    wire clr_tot = pend_r & lat_cnt & (lat_idx == 5'(I_TOT));

    property p_bin_65;
        @(posedge hclk) disable iff (!hresetn)
        (rx_evt.done && rx_evt.len == `MSC_LEN_65 && !clr_b65 &&
            cnt_r[I_B65] != '1)
        |=> cnt_r[I_B65] == $past(cnt_r[I_B65]) + 30'h1;
    endproperty
    a_bin_65: assert property (p_bin_65)
        else $error("65 octet frame not counted");

    property p_bin_max;
        @(posedge hclk) disable iff (!hresetn)
        (rx_evt.done && rx_evt.len > maxlen_r && !clr_b1024)
        |=> $stable(cnt_r[I_B1024]);
    endproperty
    a_bin_max: assert property (p_bin_max)
        else $error("frame above maximum size counted");

    property p_hi_octets;
        @(posedge hclk) disable iff (!hresetn)
        (tx_evt.done && tx_evt.good && tx_evt.high_prio && !clr_txhi &&
            cnt_r[I_TXHI] < 30'h3FFFF000)
        |=> cnt_r[I_TXHI] ==
            $past(cnt_r[I_TXHI]) + {19'h00000, $past(tx_evt.octets)};
    endproperty
    a_hi_octets: assert property (p_hi_octets)
        else $error("high priority octets not added");

    property p_early_coll;
        @(posedge hclk) disable iff (!hresetn)
        (coll_evt.hit && coll_evt.bit_pos <= `MSC_LATE_BT && !clr_late)
        |=> $stable(cnt_r[I_LATE]);
    endproperty
    a_early_coll: assert property (p_early_coll)
        else $error("early collision counted as late");

    property p_bc_not_mc;
        @(posedge hclk) disable iff (!hresetn)
        (tx_evt.done && tx_evt.bcast && !clr_mc)
        |=> $stable(cnt_r[I_MC]);
    endproperty
    a_bc_not_mc: assert property (p_bc_not_mc)
        else $error("broadcast frame counted as multicast");

    property p_full_duplex;
        @(posedge hclk) disable iff (!hresetn)
        (!hd_r && !clr_tot) |=> $stable(cnt_r[I_TOT]);
    endproperty
    a_full_duplex: assert property (p_full_duplex)
        else $error("collision total moved in full duplex");

    sequence s_trigger;
        trig;
    endsequence

    // only the two drop counters latch with valid clear; all else reads valid
    sequence s_latched;
        pend_r ##1 (data_r[`MSC_VLD_BIT] ==
            ((lat_ofs != `MSC_OFS_TXDROP) && (lat_ofs != `MSC_OFS_RXDROP)));
    endsequence

    property p_valid_after_trig;
        @(posedge hclk) disable iff (!hresetn)
        s_trigger |=> !data_r[`MSC_VLD_BIT] ##0 s_latched;
    endproperty
    a_valid_after_trig: assert property (p_valid_after_trig)
        else $error("valid flag wrong around a counter read");

    property p_read_clears;
        @(posedge hclk) disable iff (!hresetn)
        (clr_b65 && !rx_evt.done) |=> cnt_r[I_B65] == '0 && !ovf_r[I_B65];
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("counter not cleared by read");

    property p_drop_kept;
        @(posedge hclk) disable iff (!hresetn)
        (pend_r && lat_ofs == `MSC_OFS_TXDROP && !tx_drop)
        |=> txd_r == $past(txd_r) && data_r[31:`MSC_HALF_HI] == 16'h0000;
    endproperty
    a_drop_kept: assert property (p_drop_kept)
        else $error("drop counter changed by read");

    property p_upper_half;
        @(posedge hclk) disable iff (!hresetn)
        (rd_cap && ap_addr_r == `MSC_DHI_OFS)
        |=> hrdata == {16'h0000, $past(data_r[31:`MSC_HALF_HI])};
    endproperty
    a_upper_half: assert property (p_upper_half)
        else $error("upper data half read wrong");

endmodule : msc_top
`default_nettype wire

// >>> bench/mib_statistics_counters_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "msc_regs.svh"

module mib_statistics_counters_tb;
    typedef struct {
        string what;
        logic [31:0] exp;
    } msc_note_s;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    msc_pkg::msc_rx_evt_s rx_evt = '0;
    msc_pkg::msc_tx_evt_s tx_evt = '0;
    msc_pkg::msc_coll_evt_s coll_evt = '0;
    logic tx_drop = 1'b0;
    logic rx_drop = 1'b0;
    logic [29:0] m [32];
    logic [10:0] maxlen = 11'h7D0;
    logic hd = 1'b0;
    logic [31:0] seed = 32'h0000928A;
    logic [31:0] r;
    logic rd_dp = 1'b0;
    msc_note_s q [$];
    msc_note_s nt;
    int n_errors = 0;
    int cmp_count = 0;
    logic [10:0] lens [12] = '{11'h040, 11'h041, 11'h07F, 11'h080, 11'h0FF,
        11'h100, 11'h1FF, 11'h200, 11'h3FF, 11'h400, 11'h7D0, 11'h7D1};

    always #25 hclk = ~hclk;

    // the one slave's ready is the bus ready
    msc_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rx_evt(rx_evt), .tx_evt(tx_evt),
        .coll_evt(coll_evt), .tx_drop(tx_drop), .rx_drop(rx_drop)
    );

    // watch read data phases and take the oldest note at each completion
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_dp <= 1'b0;
        end else begin
            if (hresp !== 1'b0) begin
                n_errors++;
                $display("wrong value hresp expected 0 seen %b", hresp);
            end
            if (rd_dp && hreadyout === 1'b1 && q.size() > 0) begin
                nt = q.pop_front();
                cmp_count++;
                if (hrdata !== nt.exp) begin
                    n_errors++;
                    $display("wrong value %s expected %h seen %h", nt.what,
                        nt.exp, hrdata);
                end
            end
            if (hreadyout === 1'b1) begin
                rd_dp <= hsel && htrans[1] && !hwrite;
            end
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // frame flags kept legal: an abandoned frame is never good
    function automatic msc_pkg::msc_tx_evt_s rnd_tx(input logic [31:0] v);
        msc_pkg::msc_tx_evt_s t;
        t = '0;
        t.done = 1'b1;
        t.abandoned = v[0] & v[1];
        t.good = !t.abandoned && !(v[2] && v[3]);
        t.high_prio = v[5];
        t.pause = v[6];
        t.bcast = v[7] & !v[8];
        t.mcast = v[8] & !v[7];
        t.deferred = t.good & v[9];
        t.coll_num = t.abandoned ? 5'h10 : {3'h0, v[11:10]};
        t.octets = {1'b0, v[25:16]} + 11'h040;
        return t;
    endfunction : rnd_tx

    // one single transfer; held until ready is sampled high
    task automatic bus(input logic wr, input logic [31:0] a,
            input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic rd(input logic [31:0] a, input logic [31:0] e,
            input string w);
        msc_note_s n;
        n.what = w;
        n.exp = e;
        q.push_back(n);
        bus(1'b0, a, 32'h0);
    endtask : rd

    // trigger then upper half first, as software does
    task automatic rd_cnt(input int o, input logic [31:0] e);
        bus(1'b1, {24'h0, `MSC_IAC_OFS}, 32'h1C00 | o);
        rd({24'h0, `MSC_DHI_OFS}, {16'h0, e[31:16]}, $sformatf("hi %0h", o));
        rd({24'h0, `MSC_DLO_OFS}, {16'h0, e[15:0]}, $sformatf("lo %0h", o));
    endtask : rd_cnt

    task automatic drop_rd(input int o, input logic [15:0] e);
        bus(1'b1, {24'h0, `MSC_IAC_OFS}, 32'h1C00 | o);
        rd({24'h0, `MSC_DLO_OFS}, {16'h0, e}, $sformatf("drop %0h", o));
    endtask : drop_rd

    // every counter must read valid with the modelled count, then clear
    task automatic check_all();
        for (int o = 15; o < 32; o++) begin
            rd_cnt(o, {2'b01, m[o]});
            m[o] = '0;
        end
    endtask : check_all

    task automatic idle();
        rx_evt <= '0;
        tx_evt <= '0;
        coll_evt <= '0;
        tx_drop <= 1'b0;
        rx_drop <= 1'b0;
        @(posedge hclk);
    endtask : idle

    task automatic rx(input logic [10:0] len);
        rx_evt <= '{done: 1'b1, len: len};
        if (len >= 11'h400) begin
            if (len <= maxlen) m[19]++;
        end else if (len >= 11'h200) m[18]++;
        else if (len >= 11'h100) m[17]++;
        else if (len >= 11'h080) m[16]++;
        else if (len >= 11'h041) m[15]++;
        @(posedge hclk);
    endtask : rx

    // drive one cycle of transmit and collision events and model them
    task automatic step(input msc_pkg::msc_tx_evt_s t,
            input msc_pkg::msc_coll_evt_s c);
        tx_evt <= t;
        coll_evt <= c;
        if (t.done && t.good) begin
            if (t.high_prio) m[21] = m[21] + 30'(t.octets);
            else m[20] = m[20] + 30'(t.octets);
            if (t.bcast) m[24]++;
            else if (t.mcast) m[25]++;
            else m[26]++;
            if (t.deferred) m[27]++;
            if (t.coll_num == 5'h01) m[30]++;
            if (t.coll_num > 5'h01) m[31]++;
        end
        if (t.done && t.pause) m[23]++;
        if (t.done && t.abandoned) m[29]++;
        if (c.hit && c.bit_pos > 16'h0200) m[22]++;
        if (c.hit && hd) m[28]++;
        @(posedge hclk);
    endtask : step

    task automatic tx_batch();
        step('0, '{1'b1, 16'h01FF});
        step('0, '{1'b1, 16'h0200});
        step('0, '{1'b1, 16'h0201});
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            step(rnd_tx(r), '{r[27], {6'h0, r[31:22]}});
        end
        idle();
    endtask : tx_batch

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // cut a hang short well after the expected run of under a thousand cycles
    initial begin
        repeat (30000) @(posedge hclk);
        n_errors++;
        $display("wrong value run length expected end seen hang");
        results();
    end

    initial begin
        foreach (m[i]) m[i] = '0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_all();
        drop_rd(32'h100, 16'h0000);
        drop_rd(32'h103, 16'h0000);
        foreach (lens[i]) rx(lens[i]);
        for (int i = 0; i < 40; i++) rx(11'(rnd()));
        idle();
        tx_batch();
        check_all();
        bus(1'b1, {24'h0, `MSC_CFG_OFS}, 32'h000105DC);
        maxlen = 11'h5DC;
        hd = 1'b1;
        rx(11'h5DC);
        rx(11'h5DD);
        idle();
        tx_batch();
        check_all();
        rd_cnt(28, 32'h40000000);
        for (int i = 0; i < 6; i++) begin
            tx_drop <= (i < 3);
            rx_drop <= (i < 5);
            @(posedge hclk);
        end
        idle();
        for (int k = 0; k < 2; k++) begin
            drop_rd(32'h100, 16'h0003);
            drop_rd(32'h103, 16'h0005);
        end
        drop_rd(32'h101, 16'h0000);
        rd({24'h0, `MSC_IAC_OFS}, 32'h00001D01, "control readback");
        rd({24'h0, `MSC_CFG_OFS}, 32'h000105DC, "config readback");
        rd(32'h00000010, 32'h0, "unmapped read");
        bus(1'b1, 32'h00000014, 32'hFFFFFFFF);
        rd(32'h00000014, 32'h0, "unmapped after write");
        repeat (2) @(posedge hclk);
        results();
    end
endmodule : mib_statistics_counters_tb

`default_nettype wire
